// File: hdl/tsc_config_map.vh
`ifndef TSC_CONFIG_MAP_VH
`define TSC_CONFIG_MAP_VH

// ==========================================================================
// pointer values of the 16-bit words
`define TSC_PTR_CONFIG     8'h01
`define TSC_PTR_UPPER      8'h02
`define TSC_PTR_LOWER      8'h03
`define TSC_PTR_CRITICAL   8'h04
`define TSC_PTR_TEMP       8'h05
`define TSC_PTR_RESET      8'h00

// ==========================================================================
// configuration word fields
`define TSC_CFG_RSVD_HI    15
`define TSC_CFG_RSVD_LO    11
`define TSC_CFG_HYST_HI    10
`define TSC_CFG_HYST_LO    9
`define TSC_CFG_PDOWN      8
`define TSC_CFG_CRITLOCK   7
`define TSC_CFG_WINDOW_LIMIT_LOCK    6
`define TSC_CFG_CLEAR      5
`define TSC_CFG_STATUS     4
`define TSC_CFG_OUTEN      3
`define TSC_CFG_CRITONLY   2
`define TSC_CFG_POL        1
`define TSC_CFG_MODE       0

// ==========================================================================
// limit and temperature word layout
`define TSC_LIM_MASK       16'h1FFC
`define TSC_TEMP_CRIT      15
`define TSC_TEMP_UPPER     14
`define TSC_TEMP_LOWER     13

// ==========================================================================
// hysteresis codes and amounts in sixteenths of a degree
`define TSC_HYST_OFF       2'h0
`define TSC_HYST_1P5       2'h1
`define TSC_HYST_3P0       2'h2
`define TSC_HYST_6P0       2'h3
`define TSC_HYST_1P5_AMT   14'h0018
`define TSC_HYST_3P0_AMT   14'h0030
`define TSC_HYST_6P0_AMT   14'h0060

// ==========================================================================
// reset values
`define TSC_RST_WORD       16'h0000
`define TSC_RST_HYST       2'h0
`define TSC_RST_BIT        1'b0

`endif

// File: hdl/tsc_config_reg.v
// How it works
// - reserved bits 15:11 of the configuration word always read as zero
// - hysteresis code selects off, 1.5, 3.0 or 6.0 degrees; resets to off
// - hysteresis delays clearing the upper and critical flags, and setting the lower flag, on falling temperature
// - hysteresis field holds its value while either lock is set
// - power-down halts conversion, updates and alerts, and releases the pin
// - power-down cannot be set while locked, but can always be cleared
// - register access and bus timeout supervision keep running in power-down
// - critical lock freezes the critical limit; only power-on reset clears it
// - window lock freezes upper and lower limits; only power-on reset clears it
// - alert clear releases a latched interrupt; reads zero; ignored in comparator
// - status bit reads one while the alert output is asserted
// - output enable gates the alert; frozen while either lock is set
// - critical-only restricts the alert to the critical limit; window lock freezes it
// - polarity selects active low or active high; frozen while locked
// - mode selects comparator or latched interrupt; frozen while locked
// - above-upper flag in temperature bit 14 holds until below limit minus hysteresis
// - an 8-bit pointer selects the word for the following read or write
// - writes to read-only content change nothing; write-only content reads zero
`timescale 1ns/10ps
`include "tsc_config_map.vh"

module tsc_config_reg (
  // system
  input  wire        clock,
  input  wire        rstn,
  // register access from the serial protocol engine
  input  wire        ptrWrite,
  input  wire [7:0]  ptrData,
  input  wire        regWrite,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  // converter
  input  wire        sampleValid,
  input  wire [12:0] tempSample,
  output reg         convEnable,
  // protocol engine supervision
  output reg         timeoutEnable,
  // alert pin, open drain
  output reg         alertOut,
  output reg         alertOe
);

  // ========================================================================
  // state
  reg  [7:0]  pointer;
  reg  [1:0]  hysteresisSelect;
  reg         sensorPowerDown;
  reg         criticalLimitLock;
  reg         windowLimitLock;
  reg         alertOutputEnable;
  reg         criticalOnlyAlert;
  reg         alertPolarity;
  reg         alertModeSelect;
  reg  [15:0] upperLimit;
  reg  [15:0] lowerLimit;
  reg  [15:0] criticalLimit;
  reg  [15:0] tempWord;
  reg         alertLatch;
  reg         conditionPrev;

  // ========================================================================
  // write decode
  wire        anyLock;
  wire        cfgWrite;
  wire        upperWrite;
  wire        lowerWrite;
  wire        criticalWrite;
  wire        clearRequest;

  // locks are sampled from the registers, so a write that sets a lock
  // still lands its other fields in the same access
  assign anyLock       = criticalLimitLock | windowLimitLock;
  assign cfgWrite      = regWrite && (pointer == `TSC_PTR_CONFIG);
  assign upperWrite    = regWrite && (pointer == `TSC_PTR_UPPER) && !windowLimitLock;
  assign lowerWrite    = regWrite && (pointer == `TSC_PTR_LOWER) && !windowLimitLock;
  assign criticalWrite = regWrite && (pointer == `TSC_PTR_CRITICAL)
                         && !criticalLimitLock;
  assign clearRequest  = cfgWrite && regWdata[`TSC_CFG_CLEAR]
                         && alertModeSelect;

  // ========================================================================
  // pointer
  always @(posedge clock) begin
    if (!rstn) begin
      pointer <= `TSC_PTR_RESET;
    end else if (ptrWrite) begin
      pointer <= ptrData;
    end
  end

  // ========================================================================
  // configuration fields
  // every lock test reads the registers as they stood before the write
  reg  [1:0]  next_hysteresisSelect;
  reg         next_sensorPowerDown;
  reg         next_criticalLimitLock;
  reg         next_windowLimitLock;
  reg         next_alertOutputEnable;
  reg         next_criticalOnlyAlert;
  reg         next_alertPolarity;
  reg         next_alertModeSelect;

  always @* begin
    next_hysteresisSelect  = hysteresisSelect;
    next_sensorPowerDown   = sensorPowerDown;
    next_criticalLimitLock = criticalLimitLock;
    next_windowLimitLock   = windowLimitLock;
    next_alertOutputEnable = alertOutputEnable;
    next_criticalOnlyAlert = criticalOnlyAlert;
    next_alertPolarity     = alertPolarity;
    next_alertModeSelect   = alertModeSelect;
    if (cfgWrite) begin
      if (!anyLock) begin
        next_hysteresisSelect  = regWdata[`TSC_CFG_HYST_HI:`TSC_CFG_HYST_LO];
        next_alertOutputEnable = regWdata[`TSC_CFG_OUTEN];
        next_alertPolarity     = regWdata[`TSC_CFG_POL];
        next_alertModeSelect   = regWdata[`TSC_CFG_MODE];
      end
      // leaving power-down is always allowed so a locked part can wake up
      if (!regWdata[`TSC_CFG_PDOWN]) begin
        next_sensorPowerDown = 1'b0;
      end else if (!anyLock) begin
        next_sensorPowerDown = 1'b1;
      end
      // locks are set-only; nothing but rstn brings them back
      if (regWdata[`TSC_CFG_CRITLOCK]) begin
        next_criticalLimitLock = 1'b1;
      end
      if (regWdata[`TSC_CFG_WINDOW_LIMIT_LOCK]) begin
        next_windowLimitLock = 1'b1;
      end
      if (!windowLimitLock) begin
        next_criticalOnlyAlert = regWdata[`TSC_CFG_CRITONLY];
      end
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      hysteresisSelect  <= `TSC_RST_HYST;
      sensorPowerDown   <= `TSC_RST_BIT;
      criticalLimitLock <= `TSC_RST_BIT;
      windowLimitLock   <= `TSC_RST_BIT;
      alertOutputEnable <= `TSC_RST_BIT;
      criticalOnlyAlert <= `TSC_RST_BIT;
      alertPolarity     <= `TSC_RST_BIT;
      alertModeSelect   <= `TSC_RST_BIT;
    end else begin
      hysteresisSelect  <= next_hysteresisSelect;
      sensorPowerDown   <= next_sensorPowerDown;
      criticalLimitLock <= next_criticalLimitLock;
      windowLimitLock   <= next_windowLimitLock;
      alertOutputEnable <= next_alertOutputEnable;
      criticalOnlyAlert <= next_criticalOnlyAlert;
      alertPolarity     <= next_alertPolarity;
      alertModeSelect   <= next_alertModeSelect;
    end
  end

  // ========================================================================
  // limit words
  // the mask keeps reserved limit bits at zero whatever the host sends
  reg  [15:0] next_upperLimit;
  reg  [15:0] next_lowerLimit;
  reg  [15:0] next_criticalLimit;

  always @* begin
    next_upperLimit    = upperLimit;
    next_lowerLimit    = lowerLimit;
    next_criticalLimit = criticalLimit;
    if (upperWrite) begin
      next_upperLimit = regWdata & `TSC_LIM_MASK;
    end
    if (lowerWrite) begin
      next_lowerLimit = regWdata & `TSC_LIM_MASK;
    end
    if (criticalWrite) begin
      next_criticalLimit = regWdata & `TSC_LIM_MASK;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      upperLimit    <= `TSC_RST_WORD;
      lowerLimit    <= `TSC_RST_WORD;
      criticalLimit <= `TSC_RST_WORD;
    end else begin
      upperLimit    <= next_upperLimit;
      lowerLimit    <= next_lowerLimit;
      criticalLimit <= next_criticalLimit;
    end
  end

  // ========================================================================
  // comparison with hysteresis
  reg  [13:0] hystAmount;
  wire signed [13:0] tempNow;
  wire signed [13:0] upperThr;
  wire signed [13:0] lowerThr;
  wire signed [13:0] critThr;
  wire signed [13:0] upperRel;
  wire signed [13:0] lowerRel;
  wire signed [13:0] critRel;
  reg         next_crit;
  reg         next_upper;
  reg         next_lower;

  always @* begin
    case (hysteresisSelect)
      `TSC_HYST_1P5: hystAmount = `TSC_HYST_1P5_AMT;
      `TSC_HYST_3P0: hystAmount = `TSC_HYST_3P0_AMT;
      `TSC_HYST_6P0: hystAmount = `TSC_HYST_6P0_AMT;
      default:       hystAmount = 14'h0000;
    endcase
  end

  assign tempNow  = {tempSample[12], tempSample};
  assign upperThr = {upperLimit[12], upperLimit[12:0]};
  assign lowerThr = {lowerLimit[12], lowerLimit[12:0]};
  assign critThr  = {criticalLimit[12], criticalLimit[12:0]};
  // release points sit below each threshold; one extra bit keeps the
  // subtraction from wrapping at the bottom of the range
  assign upperRel = upperThr - $signed(hystAmount);
  assign lowerRel = lowerThr - $signed(hystAmount);
  assign critRel  = critThr - $signed(hystAmount);

  // upper and critical flags set on crossing and drop once below the release point; the lower flag sets below lowerRel and drops at lowerThr
  always @* begin
    next_crit  = (tempNow > critThr);
    next_upper = (tempNow > upperThr);
    next_lower = (tempNow < lowerRel);
    if (tempWord[`TSC_TEMP_CRIT] && !(tempNow < critRel)) begin
      next_crit = 1'b1;
    end
    if (tempWord[`TSC_TEMP_UPPER] && !(tempNow < upperRel)) begin
      next_upper = 1'b1;
    end
    if (tempWord[`TSC_TEMP_LOWER] && (tempNow < lowerThr)) begin
      next_lower = 1'b1;
    end
  end

  // ========================================================================
  // temperature word
  always @(posedge clock) begin
    if (!rstn) begin
      tempWord <= `TSC_RST_WORD;
    end else if (sampleValid && !sensorPowerDown) begin
      tempWord <= {next_crit, next_upper, next_lower, tempSample};
    end
  end

  // ========================================================================
  // alert generation
  wire        condition;
  wire        newEvent;
  wire        alertActive;

  assign condition = criticalOnlyAlert ? tempWord[`TSC_TEMP_CRIT]
                     : (tempWord[`TSC_TEMP_CRIT] | tempWord[`TSC_TEMP_UPPER]
                        | tempWord[`TSC_TEMP_LOWER]);
  assign newEvent  = condition && !conditionPrev && alertOutputEnable
                     && !sensorPowerDown;

  reg         next_alertLatch;

  // a new event in the same cycle as a clear keeps the latch set
  always @* begin
    next_alertLatch = alertLatch;
    if (newEvent) begin
      next_alertLatch = 1'b1;
    end else if (clearRequest || !alertModeSelect) begin
      next_alertLatch = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      alertLatch    <= `TSC_RST_BIT;
      conditionPrev <= `TSC_RST_BIT;
    end else begin
      conditionPrev <= condition;
      alertLatch    <= next_alertLatch;
    end
  end

  // a pending latch survives power-down and shows again on exit
  assign alertActive = alertOutputEnable && !sensorPowerDown
                       && (alertModeSelect ? alertLatch : condition);

  // ========================================================================
  // pin and converter control
  reg         next_alertOe;

  // open drain: pull low when asserted active-low, or idle active-high;
  // the pull-up alone can show a high level, so the pin never drives one
  always @* begin
    next_alertOe = 1'b0;
    if (!sensorPowerDown) begin
      next_alertOe = alertActive ? !alertPolarity : alertPolarity;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      alertOut      <= `TSC_RST_BIT;
      alertOe       <= `TSC_RST_BIT;
      convEnable    <= `TSC_RST_BIT;
      timeoutEnable <= `TSC_RST_BIT;
    end else begin
      alertOut      <= 1'b0;
      alertOe       <= next_alertOe;
      convEnable    <= !sensorPowerDown;
      timeoutEnable <= 1'b1;
    end
  end

  // ========================================================================
  // read data
  wire [15:0] cfgRead;

  assign cfgRead = {5'h00,
                    hysteresisSelect,
                    sensorPowerDown,
                    criticalLimitLock,
                    windowLimitLock,
                    1'b0,
                    alertActive,
                    alertOutputEnable,
                    criticalOnlyAlert,
                    alertPolarity,
                    alertModeSelect};

  // reads stay live in power-down; unmapped pointers read zero
  reg  [15:0] next_regRdata;

  always @* begin
    case (pointer)
      `TSC_PTR_CONFIG:   next_regRdata = cfgRead;
      `TSC_PTR_UPPER:    next_regRdata = upperLimit;
      `TSC_PTR_LOWER:    next_regRdata = lowerLimit;
      `TSC_PTR_CRITICAL: next_regRdata = criticalLimit;
      `TSC_PTR_TEMP:     next_regRdata = tempWord;
      default:           next_regRdata = `TSC_RST_WORD;
    endcase
  end

  // registered so the read word never glitches while the host samples it
  always @(posedge clock) begin
    if (!rstn) begin
      regRdata <= `TSC_RST_WORD;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule

// File: sim/tsc_config_chk.sv
`timescale 1ns/10ps
module tsc_config_chk (
  // system
  input wire        clock,
  input wire        rstn,
  // register port
  input wire        ptrWrite,
  input wire [7:0]  ptrData,
  input wire        regWrite,
  input wire [15:0] regWdata,
  input wire [15:0] regRdata,
  // converter, supervision, pin
  input wire        sampleValid,
  input wire [12:0] tempSample,
  input wire        convEnable,
  input wire        timeoutEnable,
  input wire        alertOut,
  input wire        alertOe
);
  // ==========================================================
  // pointer shadow: read data lags the pointer by one sample
  logic [7:0] ptr;
  logic [7:0] ptrPrev;
  wire        onCfg = (ptr == 8'h01) && (ptrPrev == 8'h01);
  wire        lock  = regRdata[7] | regRdata[6];
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ptr     <= 8'h00;
      ptrPrev <= 8'h00;
    end else begin
      if (ptrWrite) begin
        ptr <= ptrData;
      end
      ptrPrev <= ptr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence cfg2;
    onCfg [*2];
  endsequence
  sequence lockedBefore;
    cfg2 ##0 $past(lock);
  endsequence
  // ==========================================================
  // assertions
  rsvd_zero_a: assert property (onCfg |-> regRdata[15:11] == 5'h00 && !regRdata[5])
    else $error("reserved or clear bit reads one");
  lock_sticky_a: assert property (cfg2 |-> (regRdata[7:6] | $past(regRdata[7:6])) == regRdata[7:6])
    else $error("lock bit dropped");
  frozen_fields_a: assert property (lockedBefore |-> $stable({regRdata[10:9], regRdata[3], regRdata[1:0]}))
    else $error("locked field changed");
  crit_frozen_a: assert property (cfg2 ##0 $past(regRdata[6]) |-> $stable(regRdata[2]))
    else $error("critical-only changed under window lock");
  pdown_refused_a: assert property (lockedBefore ##0 $past(!regRdata[8]) |-> !regRdata[8])
    else $error("power-down set while locked");
  pdown_halt_a: assert property ((onCfg && regRdata[8]) [*3] |-> !convEnable && !alertOe)
    else $error("power-down did not halt");
  conv_run_a: assert property ((onCfg && !regRdata[8]) [*3] |-> convEnable)
    else $error("converter stopped while running");
  timeout_on_a: assert property (rstn [*3] |-> timeoutEnable)
    else $error("timeout supervision off");
  open_drain_a: assert property (alertOut == 1'b0)
    else $error("alert pin driven high");
  status_pin_a: assert property (cfg2 |-> alertOe == (!regRdata[8] && (regRdata[4] ^ regRdata[1])))
    else $error("status and pin disagree");
endmodule

bind tsc_config_reg tsc_config_chk u_chk (.clock(clock), .rstn(rstn), .ptrWrite(ptrWrite),
  .ptrData(ptrData), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
  .sampleValid(sampleValid), .tempSample(tempSample), .convEnable(convEnable),
  .timeoutEnable(timeoutEnable), .alertOut(alertOut), .alertOe(alertOe));

// File: sim/tsc_host_model.sv
`timescale 1ns/10ps
module tsc_host_model (
  // system
  input wire          clock,
  // register port toward the sensor
  output logic        ptrWrite,
  output logic [7:0]  ptrData,
  output logic        regWrite,
  output logic [15:0] regWdata
);
  initial begin
    ptrWrite = 1'b0;
    ptrData  = 8'h00;
    regWrite = 1'b0;
    regWdata = 16'h0000;
  end
  // ==========================================================
  // released lines show the inverse of the requested value; writes drive only data bits 10:0
  task automatic setPtr(input logic [7:0] p);
    @(posedge clock);
    ptrWrite <= 1'b1;
    ptrData  <= p;
    @(posedge clock);
    ptrWrite <= 1'b0;
    ptrData  <= ~p;
  endtask
  task automatic wrWord(input logic [7:0] p, input logic [15:0] d);
    setPtr(p);
    regWrite <= 1'b1;
    regWdata <= d & 16'h07FF;
    @(posedge clock);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clock       = 1'b0;
  logic        rstn        = 1'b0;
  logic        sampleValid = 1'b0;
  logic [12:0] tempSample  = 13'h0000;
  logic [15:0] rv;
  wire         ptrWrite;
  wire  [7:0]  ptrData;
  wire         regWrite;
  wire  [15:0] regWdata;
  wire  [15:0] regRdata;
  wire         convEnable;
  wire         timeoutEnable;
  wire         alertOut;
  wire         alertOe;
  int          num_errors  = 0;
  int          n_checks    = 0;
  always #10 clock = ~clock;
  tsc_host_model host (.clock(clock), .ptrWrite(ptrWrite), .ptrData(ptrData),
    .regWrite(regWrite), .regWdata(regWdata));
  tsc_config_reg dut (.clock(clock), .rstn(rstn), .ptrWrite(ptrWrite), .ptrData(ptrData),
    .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata), .sampleValid(sampleValid),
    .tempSample(tempSample), .convEnable(convEnable), .timeoutEnable(timeoutEnable),
    .alertOut(alertOut), .alertOe(alertOe));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] p, input logic [15:0] e);
    host.setPtr(p);
    repeat (3) @(posedge clock);
    #1 rv = regRdata;
    chk("regRdata", e, rv);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    host.wrWord(p, d);
    repeat (2) @(posedge clock);
  endtask
  task automatic smp(input logic [12:0] t, input logic e);
    @(posedge clock);
    sampleValid <= 1'b1;
    tempSample  <= t;
    @(posedge clock);
    sampleValid <= 1'b0;
    tempSample  <= ~t;
    repeat (3) @(posedge clock);
    #1 chk("alertOe", {15'h0, e}, {15'h0, alertOe});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_fields;
    rc(8'h01, 16'h0000);
    rc(8'h09, 16'h0000);
    wr(8'h01, 16'h072F);
    rc(8'h01, 16'h070F);
    chk("convEnable", 16'h0000, {15'h0, convEnable});
    smp(13'h0123, 1'b0);
    rc(8'h05, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, 16'(c) << 9);
      rc(8'h01, 16'(c) << 9);
    end
    $display("t_fields done");
  endtask
  task automatic t_alert;
    wr(8'h04, 16'h0FF0);
    wr(8'h02, 16'h0100);
    wr(8'h01, 16'h0208);
    smp(13'h0101, 1'b1);
    rc(8'h05, 16'h4101);
    rc(8'h01, 16'h0218);
    smp(13'h00E8, 1'b1);
    rc(8'h05, 16'h40E8);
    smp(13'h00E7, 1'b0);
    wr(8'h01, 16'h020C);
    smp(13'h0101, 1'b0);
    wr(8'h04, 16'h0100);
    smp(13'h0102, 1'b1);
    smp(13'h0050, 1'b0);
    wr(8'h01, 16'h0209);
    smp(13'h0102, 1'b1);
    smp(13'h0050, 1'b1);
    wr(8'h01, 16'h0229);
    chk("alertOe", 16'h0000, {15'h0, alertOe});
    wr(8'h01, 16'h020A);
    smp(13'h0050, 1'b1);
    smp(13'h0102, 1'b0);
    $display("t_alert done");
  endtask
  task automatic t_lock;
    wr(8'h01, 16'h0100);
    wr(8'h01, 16'h01C0);
    wr(8'h01, 16'h00C0);
    rc(8'h01, 16'h00C0);
    wr(8'h01, 16'h07CF);
    rc(8'h01, 16'h00C0);
    wr(8'h04, 16'h0040);
    rc(8'h04, 16'h0100);
    wr(8'h02, 16'h0040);
    rc(8'h02, 16'h0100);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rc(8'h01, 16'h0000);
    $display("t_lock done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_fields;
    t_alert;
    t_lock;
    final_report;
  end
endmodule
